// File: dmrs_pkg.sv
// Package for the loop mode and reference choice block
package dmrs_pkg;
  // Register offsets and reset values
  localparam logic [7:0] MODE_REG_ADDR      = 8'h38;
  localparam logic [7:0] MODE_REG_RESET     = 8'h03;
  localparam logic [7:0] FAILMASK_REG_ADDR  = 8'h39;
  localparam logic [7:0] FAILMASK_REG_RESET = 8'h87;
  // Field positions in the mode register
  localparam int MODE_LSB   = 0;
  localparam int RSVD_LSB   = 2;
  localparam int EXTFB_BIT  = 5;
  localparam int REFSEL_LSB = 6;
  localparam logic [2:0] RSVD_DEFAULT = 3'h0;
  // Priority layout and count of references
  localparam int              NUM_REFS      = 4;
  localparam int              PRIO_W        = 3;
  localparam logic [PRIO_W-1:0] PRIO_DISABLED = 3'h7;
  localparam logic [PRIO_W-1:0] PRIO_RESET    = 3'h0;

  // Operating modes as the two-bit field encodes them
  typedef enum logic [1:0] {
    DMRS_FREERUN  = 2'b00,
    DMRS_HOLDOVER = 2'b01,
    DMRS_FORCED   = 2'b10,
    DMRS_AUTO     = 2'b11
  } dmrs_mode_t;

  // Loop state shown to the phase-locking loop
  typedef enum logic [1:0] {
    DMRS_ST_FREERUN = 2'b00,
    DMRS_ST_LOCKING = 2'b01,
    DMRS_ST_HOLD    = 2'b10
  } dmrs_state_t;

  // Register access strobe group
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmrs_regreq_t;

  // Control handed to the loop
  typedef struct packed {
    dmrs_state_t state;
    logic [1:0]  activeRef;
    logic        useOscOnly;
    logic        extFbOn;
  } dmrs_loopctl_t;
endpackage : dmrs_pkg

// File: dmrs_ref_picker.sv
// Automatic reference picker with revertive and non-revertive switching
`timescale 1ns/100ps
module dmrs_ref_picker #(
  parameter int NREF = dmrs_pkg::NUM_REFS,
  parameter int PW   = dmrs_pkg::PRIO_W
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  // Inputs
  input  wire logic                    enable,
  input  wire logic [NREF-1:0]         refAvail,
  input  wire logic [NREF*PW-1:0]      refRank,
  // Outputs
  output logic      [$clog2(NREF)-1:0] pickedRef,
  output logic                         anyUsable
);
  import dmrs_pkg::*;

  localparam int IW = $clog2(NREF);

  // Usable means available and not disabled by rank
  function automatic logic usable(input logic av, input logic [PW-1:0] rk);
    return av && (rk != PRIO_DISABLED[PW-1:0]);
  endfunction : usable

  logic [NREF-1:0] use_v;
  genvar g;
  generate
    for (g = 0; g < NREF; g++) begin : g_use
      assign use_v[g] = usable(refAvail[g], refRank[g*PW +: PW]);
    end
  endgenerate

  // Best candidate: lowest rank wins, lowest index breaks ties
  logic [IW-1:0] bestIdx;
  logic [PW-1:0] bestRank;
  always_comb begin
    bestIdx  = '0;
    bestRank = PRIO_DISABLED[PW-1:0];
    for (int i = NREF - 1; i >= 0; i--) begin
      if (use_v[i] && refRank[i*PW +: PW] <= bestRank) begin
        bestIdx  = IW'(i);
        bestRank = refRank[i*PW +: PW];
      end
    end
  end

  wire            curUsable = use_v[pickedRef];
  wire [PW-1:0]   curRank   = refRank[pickedRef*PW +: PW];
  assign anyUsable = |use_v;
  // Stay on equal rank, revert only to a strictly better one
  wire            doSwitch  = !curUsable || (bestRank < curRank);

  // Selection memory; kept while disabled so holdover knows the last ref
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pickedRef <= '0;
    end else if (enable && anyUsable && doSwitch) begin
      pickedRef <= bestIdx;
    end
  end
endmodule : dmrs_ref_picker

// File: dmrs_mode_ctrl.sv
// Loop mode and reference choice control with its two registers
// Behaviour
// - Mode field 00 freerun, 01 forced holdover, 10 forced reference, 11 automatic.
// - Automatic picks by availability and rank; holdover only when none usable.
// - Forced mode tracks only chosen reference; holdover if it fails, never switch.
// - Forced holdover ignores references, holds on the last locked reference.
// - Freerun derives outputs only from the local oscillator input.
// - Feedback enable set uses external feedback phase; clear ignores it.
// - The single feedback phase is used whenever enabled, whatever loop makes it.
// - In automatic mode the reference field reads back the selected reference.
// - In forced mode the reference field is writable, choosing reference 0 to 3.
// - In freerun and forced holdover the reference field is ignored.
// - Lower rank wins, 111 disables, revert to better, no equal-rank switching.
`timescale 1ns/100ps
module dmrs_mode_ctrl #(
  parameter int NREF = dmrs_pkg::NUM_REFS,
  parameter int PW   = dmrs_pkg::PRIO_W
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // Register port
  input  dmrs_pkg::dmrs_regreq_t     regReq,
  output logic [7:0]                 regRdata,
  output logic                       regRvalid,
  // Reference monitor indications and ranks
  input  wire logic [NREF-1:0]       refAvail,
  input  wire logic [NREF*PW-1:0]    refRank,
  // Control to the loop
  output dmrs_pkg::dmrs_loopctl_t    loopCtl,
  output logic [7:0]                 refFailMask
);
  import dmrs_pkg::*;

  localparam int IW = $clog2(NREF);

  // Stored mode register fields and the last locked reference
  dmrs_mode_t    loop_operating_select;
  logic [2:0]    modeRsvd;
  logic          external_feedback_compensation_on;
  logic [IW-1:0] forcedRef;
  logic [IW-1:0] lastRef;

  // Address decode
  wire wrMode = regReq.wrEn && (regReq.addr == MODE_REG_ADDR);
  wire wrMask = regReq.wrEn && (regReq.addr == FAILMASK_REG_ADDR);

  // Mode decode
  wire isAuto     = (loop_operating_select == DMRS_AUTO);
  wire isForced   = (loop_operating_select == DMRS_FORCED);
  wire isHoldover = (loop_operating_select == DMRS_HOLDOVER);
  wire isFreerun  = (loop_operating_select == DMRS_FREERUN);

  // Automatic picker runs only in automatic mode
  logic [IW-1:0] autoRef;
  logic          anyUsable;
  dmrs_ref_picker #(
    .NREF (NREF),
    .PW   (PW)
  ) u_picker (
    .mclk      (mclk),
    .rstn      (rstn),
    .enable    (isAuto),
    .refAvail  (refAvail),
    .refRank   (refRank),
    .pickedRef (autoRef),
    .anyUsable (anyUsable)
  );

  // Forced reference is only judged by its own availability
  wire forcedOk = refAvail[forcedRef];

  // Loop state per mode
  dmrs_state_t next_state;
  logic [IW-1:0] next_active;
  always_comb begin
    next_state  = DMRS_ST_HOLD;
    next_active = lastRef;
    unique case (loop_operating_select)
      DMRS_FREERUN: begin
        next_state = DMRS_ST_FREERUN;
      end
      DMRS_HOLDOVER: begin
        next_state = DMRS_ST_HOLD;
      end
      DMRS_FORCED: begin
        next_active = forcedRef;
        next_state  = forcedOk ? DMRS_ST_LOCKING : DMRS_ST_HOLD;
      end
      DMRS_AUTO: begin
        next_active = autoRef;
        next_state  = anyUsable ? DMRS_ST_LOCKING : DMRS_ST_HOLD;
      end
    endcase
  end

  // Mode register storage; reference bits only take writes in forced mode or when the write selects forced mode
  wire nextForcedMode = regReq.wdata[MODE_LSB +: 2] == DMRS_FORCED;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      loop_operating_select             <= dmrs_mode_t'(MODE_REG_RESET[MODE_LSB +: 2]);
      modeRsvd                          <= MODE_REG_RESET[RSVD_LSB +: 3];
      external_feedback_compensation_on <= MODE_REG_RESET[EXTFB_BIT];
      forcedRef                         <= MODE_REG_RESET[REFSEL_LSB +: 2];
    end else if (wrMode) begin
      loop_operating_select             <= dmrs_mode_t'(regReq.wdata[MODE_LSB +: 2]);
      modeRsvd                          <= regReq.wdata[RSVD_LSB +: 3];
      external_feedback_compensation_on <= regReq.wdata[EXTFB_BIT];
      if (nextForcedMode || isForced) begin
        forcedRef <= regReq.wdata[REFSEL_LSB +: 2];
      end
    end
  end

  // Failure mask register, passed on to the monitors
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      refFailMask <= FAILMASK_REG_RESET;
    end else if (wrMask) begin
      refFailMask <= regReq.wdata;
    end
  end

  // Last locked reference, used as the holdover basis
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lastRef <= '0;
    end else if (next_state == DMRS_ST_LOCKING) begin
      lastRef <= next_active;
    end
  end

  // Registered loop control; feedback usage does not depend on its source
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      loopCtl <= '{state: DMRS_ST_FREERUN, activeRef: '0, useOscOnly: 1'b1, extFbOn: 1'b0};
    end else begin
      loopCtl.state      <= next_state;
      loopCtl.activeRef  <= next_active;
      loopCtl.useOscOnly <= isFreerun;
      loopCtl.extFbOn    <= external_feedback_compensation_on;
    end
  end

  // Read back: reference field is status in automatic mode
  wire [1:0] reference_choice_field = isAuto ? autoRef : forcedRef;
  wire [7:0] modeRead = {reference_choice_field, external_feedback_compensation_on,
                         modeRsvd, loop_operating_select};
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      regRdata  <= 8'h00;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regReq.rdEn;
      if (regReq.rdEn) begin
        regRdata <= (regReq.addr == MODE_REG_ADDR)     ? modeRead :
                    (regReq.addr == FAILMASK_REG_ADDR) ? refFailMask : 8'h00;
      end
    end
  end
endmodule : dmrs_mode_ctrl

// File: dmrs_mode_ctrl_checker.sv
// Assertion checker for the loop mode control block
`timescale 1ns/100ps
module dmrs_mode_ctrl_checker #(
  parameter int NREF = 4,
  parameter int PW   = 3
) (
  // Clock and reset
  input logic                   mclk,
  input logic                   rstn,
  // Register port
  input dmrs_pkg::dmrs_regreq_t regReq,
  input logic [7:0]             regRdata,
  input logic                   regRvalid,
  // Loop side
  input logic [NREF-1:0]        refAvail,
  input logic [NREF*PW-1:0]     refRank,
  input dmrs_pkg::dmrs_loopctl_t loopCtl,
  input logic [7:0]             refFailMask
);
  import dmrs_pkg::*;
  logic [1:0] mode;
  logic [1:0] rsel;
  logic       ext;
  wire        modeWr = regReq.wrEn && regReq.addr == MODE_REG_ADDR;
  // Shadow of the mode register; the choice field only moves around forced mode
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode <= 2'h3;
      rsel <= 2'h0;
      ext  <= 1'b0;
    end else if (modeWr) begin
      mode <= regReq.wdata[1:0];
      ext  <= regReq.wdata[5];
      if (regReq.wdata[1:0] == 2'h2 || mode == 2'h2) rsel <= regReq.wdata[7:6];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_FREERUN: assert property (mode == 2'h0 |=> loopCtl.useOscOnly)
    else $error("freerun not on oscillator");
  AST_HOLDOVER: assert property (mode == 2'h1 |=> loopCtl.state == DMRS_ST_HOLD)
    else $error("forced holdover not held");
  AST_KEEPREF: assert property (!mode[1] && $past(mode) == mode |=> $stable(loopCtl.activeRef))
    else $error("reference moved while ignored");
  AST_FORCED: assert property (mode == 2'h2 |=> loopCtl.activeRef == $past(rsel) && loopCtl.state == ($past(refAvail[rsel]) ? DMRS_ST_LOCKING : DMRS_ST_HOLD))
    else $error("forced reference misfollowed");
  AST_AUTOHOLD: assert property ((mode == 2'h3 && refAvail == '0) [*3] |=> loopCtl.state == DMRS_ST_HOLD)
    else $error("auto not in holdover");
  AST_AUTOLOCK: assert property ((mode == 2'h3 && refAvail[0] && refRank[2:0] == 3'h0) [*3] |=> loopCtl.state == DMRS_ST_LOCKING)
    else $error("auto not locking");
  AST_EXTFB: assert property (1'b1 |=> loopCtl.extFbOn == $past(ext))
    else $error("feedback enable not followed");
  AST_REFREAD: assert property (regReq.rdEn && !regReq.wrEn && regReq.addr == MODE_REG_ADDR && mode == 2'h2 |=> regRvalid && regRdata[7:6] == $past(rsel))
    else $error("forced choice read back wrong");
endmodule : dmrs_mode_ctrl_checker

bind dmrs_mode_ctrl dmrs_mode_ctrl_checker #(.NREF(NREF), .PW(PW)) chkInst (
  .mclk(mclk), .rstn(rstn), .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
  .refAvail(refAvail), .refRank(refRank), .loopCtl(loopCtl), .refFailMask(refFailMask));

// File: dmrs_mode_ctrl_test.sv
// Self-checking bench for the loop mode control block
`timescale 1ns/100ps
module dmrs_mode_ctrl_test;
  import dmrs_pkg::*;
  logic          mclk = 1'b0;
  logic          rstn = 1'b0;
  dmrs_regreq_t  req = '0;
  logic [3:0]    avail = 4'hf;
  logic [11:0]   rank = 12'h688;
  logic [31:0]   seed = 32'h1cb0_0bef;
  logic [11:0]   cs [5] = '{12'h1b6, 12'h103, 12'h183, 12'h003, 12'h1e1};
  logic [11:0]   r;
  logic [7:0]    rd, rdata, fm;
  logic [1:0]    md, er;
  logic          rv;
  dmrs_state_t   st;
  dmrs_loopctl_t ctl;
  int            miscompares = 0, n_checks = 0, cyc = 0;
  dmrs_mode_ctrl dmrs_mode_ctrl_inst (.mclk(mclk), .rstn(rstn), .regReq(req), .regRdata(rdata),
    .regRvalid(rv), .refAvail(avail), .refRank(rank), .loopCtl(ctl), .refFailMask(fm));
  // 125 MHz clock
  always #4 mclk = ~mclk;
  // Hang guard, well past the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Ranks rise with index, so the lowest available index wins
  function automatic logic [1:0] best(input logic [3:0] a);
    return a[0] ? 2'h0 : a[1] ? 2'h1 : a[2] ? 2'h2 : 2'h3;
  endfunction : best
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    req.wrEn <= 1'b0;
  endtask : wr
  // Data is sampled mid-cycle, after the answering edge has settled
  task automatic rdreg(input logic [7:0] a);
    @(posedge mclk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    req.rdEn <= 1'b0;
    @(negedge mclk);
    chk("read valid", 8'(rv), 8'h01);
    rd = rdata;
  endtask : rdreg
  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // Reset values, mask access, unmapped place, then mode sweep
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rdreg(MODE_REG_ADDR);
    chk("mode reset", rd, MODE_REG_RESET);
    rdreg(FAILMASK_REG_ADDR);
    chk("mask reset", rd, FAILMASK_REG_RESET);
    wr(FAILMASK_REG_ADDR, seed[7:0]);
    wr(8'h40, ~seed[7:0]);
    rdreg(FAILMASK_REG_ADDR);
    chk("mask", fm, seed[7:0]);
    chk("mask read", rd, seed[7:0]);
    rdreg(8'h40);
    chk("unmapped", rd, 8'h00);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      r = (i < 5) ? cs[i] : seed[11:0];
      md = r[1:0];
      // Availability moves on a rising edge, never mid-cycle
      @(posedge mclk);
      avail <= r[8:5];
      wr(MODE_REG_ADDR, {r[3:2], r[4], 3'h0, md});
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      er = md[0] ? best(r[8:5]) : r[3:2];
      st = !md[1] ? (md[0] ? DMRS_ST_HOLD : DMRS_ST_FREERUN) :
           (md[0] ? r[8:5] != 4'h0 : r[er + 5]) ? DMRS_ST_LOCKING : DMRS_ST_HOLD;
      chk("state", 8'(ctl.state), 8'(st));
      chk("osc only", 8'(ctl.useOscOnly), 8'(md == 2'h0));
      chk("ext fb", 8'(ctl.extFbOn), 8'(r[4]));
      if (md == 2'h2 || st == DMRS_ST_LOCKING) chk("active", 8'(ctl.activeRef), 8'(er));
      rdreg(MODE_REG_ADDR);
      chk("mode reg", rd & 8'h3f, {2'h0, r[4], 3'h0, md});
      if (md == 2'h2 || st == DMRS_ST_LOCKING) chk("ref field", 8'(rd[7:6]), 8'(er));
    end
    // All references disabled by rank leaves nothing to lock to
    @(posedge mclk);
    rank <= 12'hfff;
    avail <= 4'hf;
    wr(MODE_REG_ADDR, 8'h03);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("disabled", 8'(ctl.state), 8'(DMRS_ST_HOLD));
    // Equal ranks: no move to a recovered peer, then revert to a better one
    @(posedge mclk);
    rank <= 12'h000;
    avail <= 4'h4;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("equal pick", 8'(ctl.activeRef), 8'h02);
    @(posedge mclk);
    avail <= 4'h5;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("no equal switch", 8'(ctl.activeRef), 8'h02);
    @(posedge mclk);
    rank <= 12'h248;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("revert", 8'(ctl.activeRef), 8'h00);
    stop_test();
  end
endmodule : dmrs_mode_ctrl_test
